// ### hw/smal_regs.sv
// smal_regs.sv: acknowledge latency timer and switch operation mode registers,
// with the per-packet mode snapshot, forwarding start point and port arbiter.
// assumes: configuration access and the management/EEPROM load path share MCLK;
// PKT_START is a one-cycle pulse from the datapath on the same clock.
//
// Operation
// - 14-bit user ack latency, bits 29:16, reset zero
// - bit 30 selects user ack latency
// - read-only vga decode bit 31 resets one
// - management or eeprom load replaces field values
// - mode bit set buffers whole packet first
// - threshold code moves start before midpoint
// - threshold applies slow port to fast port
// - hold mode keeps grant while request pends
// - otherwise move only to ports with credit
// - credit release all types or per type
// - optional ordering across different egress ports
// - optional ordering across completion tags
// - 12-bit user replay timeout plus enable
`include "smal_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module smal_regs
	import smal_pkg::*;
#(
	parameter int          LEN_W       = 12,
	parameter int          PORTS       = 4,
	parameter logic [13:0] ACK_LAT_DEF = 14'h0100,
	parameter logic [11:0] REPLAY_DEF  = 12'h400
) (
	// clock and reset
	input  wire logic             MCLK,
	input  wire logic             RST_N,
	// configuration access
	input  wire logic             CFG_WR,
	input  wire logic             CFG_RD,
	input  wire logic [7:0]       CFG_ADDR,
	input  wire logic [3:0]       CFG_BE,
	input  wire logic [31:0]      CFG_WDATA,
	output logic      [31:0]      CFG_RDATA,
	output logic                  CFG_ACK,
	// management port / eeprom auto-load
	input  wire smal_load_s       LOAD,
	// packet handling
	input  wire logic             PKT_START,
	input  wire logic [LEN_W-1:0] PKT_LEN,
	input  wire logic             PKT_SLOW_TO_FAST,
	output logic      [LEN_W-1:0] FWD_START,
	// arbitration
	input  wire logic [PORTS-1:0] REQ,
	input  wire logic [PORTS-1:0] CREDIT_OK,
	output logic      [1:0]       GRANT_IDX,
	output logic                  GRANT_VALID,
	// settings to the link and datapath
	output logic      [13:0]      ACK_LATENCY,
	output logic      [11:0]      REPLAY_TIMEOUT,
	output logic                  VGA_DECODE_EN,
	output logic                  CREDIT_ALL_TYPES,
	output logic                  ORDER_EGRESS,
	output logic                  ORDER_TAG
);

	// the grant index is two bits wide, so only a four-port build is served
	if (PORTS != 4 || LEN_W < 2) begin : g_param_chk
		$error("smal_regs: needs PORTS == 4 and LEN_W >= 2");
	end

	logic [31:0] ack_ff;
	logic [31:0] mode_ff;
	smal_mode_s  act_ff;
	logic [1:0]  gnt_idx_ff;
	logic        gnt_valid_ff;
	logic [31:0] be_mask;
	logic        cfg_ack_hit;
	logic        cfg_mode_hit;
	logic        ld_ack_hit;
	logic        ld_mode_hit;

	assign be_mask      = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
	assign cfg_ack_hit  = CFG_WR && CFG_ADDR == `SMAL_ACK_OFS;
	assign cfg_mode_hit = CFG_WR && CFG_ADDR == `SMAL_MODE_OFS;
	assign ld_ack_hit   = LOAD.valid && LOAD.addr == `SMAL_ACK_OFS;
	assign ld_mode_hit  = LOAD.valid && LOAD.addr == `SMAL_MODE_OFS;

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	// the load path wins over a config write in the same cycle: it is the
	// only way the read-only bits move, so it must not be shadowed
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ack_ff <= `SMAL_ACK_RST;
		end else if (ld_ack_hit) begin
			ack_ff <= LOAD.data & `SMAL_ACK_LOAD_MASK;
		end else if (cfg_ack_hit) begin
			ack_ff <= (ack_ff & ~(be_mask & `SMAL_ACK_CFG_MASK))
				| (CFG_WDATA & be_mask & `SMAL_ACK_CFG_MASK);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mode_ff <= `SMAL_MODE_RST;
		end else if (ld_mode_hit) begin
			mode_ff <= LOAD.data & `SMAL_MODE_LOAD_MASK;
		end else if (cfg_mode_hit) begin
			mode_ff <= (mode_ff & ~(be_mask & `SMAL_MODE_CFG_MASK))
				| (CFG_WDATA & be_mask & `SMAL_MODE_CFG_MASK);
		end
	end

	// ------------------------------------------------------------------
	// configuration read
	// ------------------------------------------------------------------
	// unmapped offsets read zero; writes to them are dropped
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			CFG_RDATA <= 32'h0000_0000;
			CFG_ACK   <= 1'b0;
		end else begin
			CFG_ACK <= CFG_RD || CFG_WR;
			if (CFG_RD && CFG_ADDR == `SMAL_ACK_OFS) begin
				CFG_RDATA <= ack_ff;
			end else if (CFG_RD && CFG_ADDR == `SMAL_MODE_OFS) begin
				CFG_RDATA <= mode_ff;
			end else begin
				CFG_RDATA <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------------
	// latency settings to the link layer and vga decode enable
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ACK_LATENCY    <= ACK_LAT_DEF;
			REPLAY_TIMEOUT <= REPLAY_DEF;
			VGA_DECODE_EN  <= 1'b1;
		end else begin
			ACK_LATENCY    <= ack_ff[`SMAL_ACKLAT_EN_BIT]
				? ack_ff[`SMAL_ACKLAT_MSB:`SMAL_ACKLAT_LSB] : ACK_LAT_DEF;
			REPLAY_TIMEOUT <= ack_ff[`SMAL_REPLAY_EN_BIT]
				? ack_ff[`SMAL_REPLAY_MSB:`SMAL_REPLAY_LSB] : REPLAY_DEF;
			VGA_DECODE_EN  <= ack_ff[`SMAL_VGA_BIT];
		end
	end

	// ------------------------------------------------------------------
	// per-packet mode snapshot
	// ------------------------------------------------------------------
	// sampling only at packet start keeps a packet in flight on one mode
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			act_ff <= smal_mode_s'(7'(`SMAL_MODE_RST));
		end else if (PKT_START) begin
			act_ff <= smal_mode_s'(mode_ff[`SMAL_MODE_MSB:`SMAL_MODE_LSB]);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			CREDIT_ALL_TYPES <= 1'b0;
			ORDER_EGRESS     <= 1'b0;
			ORDER_TAG        <= 1'b0;
		end else begin
			CREDIT_ALL_TYPES <= act_ff.credit_all;
			ORDER_EGRESS     <= act_ff.ord_egress;
			ORDER_TAG        <= act_ff.ord_tag;
		end
	end

	// ------------------------------------------------------------------
	// forwarding start point
	// ------------------------------------------------------------------
	smal_mode_s       now_mode;
	logic [LEN_W-1:0] mid_pt;
	logic [LEN_W-1:0] thr_ext;
	logic [LEN_W-1:0] ct_start;

	assign now_mode = smal_mode_s'(mode_ff[`SMAL_MODE_MSB:`SMAL_MODE_LSB]);
	assign mid_pt   = PKT_LEN >> 1;
	assign thr_ext  = LEN_W'(now_mode.ct_thr);
	// short packets clamp to the first cycle rather than wrap
	assign ct_start = (mid_pt > thr_ext) ? mid_pt - thr_ext : '0;

	// same-speed cut-through starts at once; the threshold only matters when
	// the egress drains faster than the ingress fills
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			FWD_START <= '0;
		end else if (PKT_START) begin
			if (now_mode.store_fwd) begin
				FWD_START <= PKT_LEN;
			end else if (PKT_SLOW_TO_FAST) begin
				FWD_START <= ct_start;
			end else begin
				FWD_START <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// round-robin port arbiter
	// ------------------------------------------------------------------
	logic [1:0] nxt_gnt_idx;
	logic       nxt_gnt_valid;

	always_comb begin
		logic [1:0] cand;
		nxt_gnt_idx   = gnt_idx_ff;
		nxt_gnt_valid = 1'b0;
		cand          = 2'h0;
		if (act_ff.arb_hold && gnt_valid_ff && REQ[gnt_idx_ff]) begin
			nxt_gnt_valid = 1'b1;
		end else begin
			for (int i = 4; i >= 1; i--) begin
				cand = gnt_idx_ff + 2'(i);
				if (REQ[cand] && CREDIT_OK[cand]) begin
					nxt_gnt_idx   = cand;
					nxt_gnt_valid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			gnt_idx_ff   <= 2'h3;
			gnt_valid_ff <= 1'b0;
		end else begin
			gnt_idx_ff   <= nxt_gnt_idx;
			gnt_valid_ff <= nxt_gnt_valid;
		end
	end

	assign GRANT_IDX   = gnt_idx_ff;
	assign GRANT_VALID = gnt_valid_ff;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	AST_ACK_RST: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(RST_N) |-> ack_ff == `SMAL_ACK_RST)
		else $error("latency register left reset with wrong value");

	AST_ACK_SEL: assert property (@(posedge MCLK) disable iff (!RST_N)
		##1 ACK_LATENCY == ($past(ack_ff[`SMAL_ACKLAT_EN_BIT])
			? $past(ack_ff[`SMAL_ACKLAT_MSB:`SMAL_ACKLAT_LSB]) : ACK_LAT_DEF))
		else $error("ack latency does not follow enable");

	AST_REPLAY_SEL: assert property (@(posedge MCLK) disable iff (!RST_N)
		##1 REPLAY_TIMEOUT == ($past(ack_ff[`SMAL_REPLAY_EN_BIT])
			? $past(ack_ff[`SMAL_REPLAY_MSB:`SMAL_REPLAY_LSB]) : REPLAY_DEF))
		else $error("replay timeout does not follow enable");

	AST_VGA_RO: assert property (@(posedge MCLK) disable iff (!RST_N)
		(CFG_WR && !LOAD.valid) |=> $stable(ack_ff[`SMAL_VGA_BIT]) && $stable(mode_ff[31:7]))
		else $error("config write changed a read-only bit");

	AST_LOAD: assert property (@(posedge MCLK) disable iff (!RST_N)
		ld_ack_hit |=> ack_ff == ($past(LOAD.data) & `SMAL_ACK_LOAD_MASK))
		else $error("load did not replace latency register");

	AST_SF: assert property (@(posedge MCLK) disable iff (!RST_N)
		(PKT_START && now_mode.store_fwd) |=> FWD_START == $past(PKT_LEN))
		else $error("store-forward start is not the packet end");

	AST_CT: assert property (@(posedge MCLK) disable iff (!RST_N)
		(PKT_START && !now_mode.store_fwd && PKT_SLOW_TO_FAST
			&& (PKT_LEN >> 1) > LEN_W'(3))
		|=> FWD_START == ($past(PKT_LEN) >> 1) - LEN_W'($past(now_mode.ct_thr)))
		else $error("cut-through start misplaced");

	AST_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
		(act_ff.arb_hold && gnt_valid_ff && REQ[gnt_idx_ff])
		|=> gnt_valid_ff && gnt_idx_ff == $past(gnt_idx_ff))
		else $error("held grant moved while request pending");

	AST_CREDIT: assert property (@(posedge MCLK) disable iff (!RST_N)
		(!act_ff.arb_hold ##1 gnt_valid_ff)
		|-> (($past(REQ & CREDIT_OK) >> gnt_idx_ff) & 4'h1) == 4'h1)
		else $error("grant to port without credit");

	AST_SNAP: assert property (@(posedge MCLK) disable iff (!RST_N)
		!PKT_START |=> $stable(act_ff))
		else $error("mode snapshot changed mid-packet");

endmodule : smal_regs

`default_nettype wire

// ### hw/smal_defines.svh
// smal_defines.svh: offsets, field positions, reset values and masks for the
// acknowledge latency / switch mode register pair.
// assumes: 8-bit byte addresses on the configuration access port.
`ifndef SMAL_DEFINES_SVH
`define SMAL_DEFINES_SVH

`define SMAL_ACK_OFS        8'h70
`define SMAL_MODE_OFS       8'h74

// latency register fields
`define SMAL_REPLAY_LSB     0
`define SMAL_REPLAY_MSB     11
`define SMAL_REPLAY_EN_BIT  12
`define SMAL_ACKLAT_LSB     16
`define SMAL_ACKLAT_MSB     29
`define SMAL_ACKLAT_EN_BIT  30
`define SMAL_VGA_BIT        31

// mode register fields
`define SMAL_MODE_LSB       0
`define SMAL_MODE_MSB       6

`define SMAL_ACK_RST        32'h8000_0000
`define SMAL_MODE_RST       32'h0000_0002
// software-writable bits; the load path may also set the read-only vga bit 31
`define SMAL_ACK_CFG_MASK   32'h7fff_1fff
`define SMAL_ACK_LOAD_MASK  32'hffff_1fff
`define SMAL_MODE_CFG_MASK  32'h0000_007f
`define SMAL_MODE_LOAD_MASK 32'h0000_007f

`endif

// ### hw/smal_pkg.sv
// smal_pkg.sv: types shared by the switch mode / latency register block.
// assumes: field layout of the mode register bits 6:0.
package smal_pkg;

	// same order as the mode register bits 6:0
	typedef struct packed {
		logic       ord_tag;
		logic       ord_egress;
		logic       credit_all;
		logic       arb_hold;
		logic [1:0] ct_thr;
		logic       store_fwd;
	} smal_mode_s;

	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [31:0] data;
	} smal_load_s;

endpackage : smal_pkg

// ### bench/smal_load_model.sv
// smal_load_model.sv: management / eeprom auto-load source for the register block.
// assumes: shares MCLK with the block; the bench calls send between clock edges.
`timescale 1ns/1ps
`default_nettype none

module smal_load_model
	import smal_pkg::*;
(
	// clock and load path
	input  wire logic        MCLK,
	output var  smal_load_s  LOAD
);
	// ----------------------------------------
	// load source
	// ----------------------------------------
	initial LOAD = '0;

	// whole word per load, valid for one cycle only
	task automatic send(input logic [7:0] addr, input logic [31:0] data);
		@(posedge MCLK);
		#1;
		LOAD = '{valid: 1'b1, addr: addr, data: data};
		@(posedge MCLK);
		#1;
		LOAD.valid = 1'b0;
	endtask : send
endmodule : smal_load_model

`default_nettype wire

// ### bench/smal_regs_tb_top.sv
// smal_regs_tb_top.sv: self-checking bench for the latency / mode register pair.
// assumes: smal_pkg, smal_defines.svh and smal_load_model are compiled first.
`include "smal_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module smal_regs_tb_top
	import smal_pkg::*;
;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam logic [13:0] ADEF = 14'h0123;
	localparam logic [11:0] RDEF = 12'h456;
	logic        MCLK, RST_N, CFG_WR, CFG_RD, CFG_ACK, PKT_START, PKT_SLOW_TO_FAST;
	logic        GRANT_VALID, VGA_DECODE_EN, CREDIT_ALL_TYPES, ORDER_EGRESS, ORDER_TAG;
	logic [7:0]  CFG_ADDR;
	logic [3:0]  CFG_BE, REQ, CREDIT_OK;
	logic [31:0] CFG_WDATA, CFG_RDATA, d, seed_v;
	logic [11:0] PKT_LEN, FWD_START, REPLAY_TIMEOUT;
	logic [13:0] ACK_LATENCY;
	logic [1:0]  GRANT_IDX;
	smal_load_s  LOAD;
	logic [31:0] exp_q[$];
	logic        rd_q = 1'b0;
	logic        wr_q = 1'b0;
	int          num_errors = 0, total_checks = 0, cycles = 0;

	smal_regs #(.ACK_LAT_DEF(ADEF), .REPLAY_DEF(RDEF)) smal_regs_i (.MCLK(MCLK),
		.RST_N(RST_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
		.CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
		.LOAD(LOAD), .PKT_START(PKT_START), .PKT_LEN(PKT_LEN),
		.PKT_SLOW_TO_FAST(PKT_SLOW_TO_FAST), .FWD_START(FWD_START), .REQ(REQ),
		.CREDIT_OK(CREDIT_OK), .GRANT_IDX(GRANT_IDX), .GRANT_VALID(GRANT_VALID),
		.ACK_LATENCY(ACK_LATENCY), .REPLAY_TIMEOUT(REPLAY_TIMEOUT),
		.VGA_DECODE_EN(VGA_DECODE_EN), .CREDIT_ALL_TYPES(CREDIT_ALL_TYPES),
		.ORDER_EGRESS(ORDER_EGRESS), .ORDER_TAG(ORDER_TAG));
	smal_load_model smal_load_model_i (.MCLK(MCLK), .LOAD(LOAD));

	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// one access per call; strobe lives for exactly one taking edge
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		@(posedge MCLK);
		#1;
		{CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {wr, !wr, a, be, wd};
		@(posedge MCLK);
		#1;
		{CFG_WR, CFG_RD} = 2'b00;
	endtask : cfg

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		cfg(1'b0, a, 4'h0, 32'h0);
	endtask : rd

	// register lands one edge after the access, outputs one edge later
	task automatic settle();
		repeat (2) @(posedge MCLK);
		#1;
	endtask : settle

	task automatic pkt(input logic [11:0] len, input logic slow);
		@(posedge MCLK);
		#1;
		{PKT_START, PKT_LEN, PKT_SLOW_TO_FAST} = {1'b1, len, slow};
		@(posedge MCLK);
		#1;
		PKT_START = 1'b0;
	endtask : pkt

	task automatic arb(input logic [3:0] r, input logic [3:0] c, input logic v,
		input logic [1:0] i);
		REQ = r;
		CREDIT_OK = c;
		@(posedge MCLK);
		#1;
		check("grant_valid", GRANT_VALID, v);
		if (v) begin
			check("grant_idx", GRANT_IDX, i);
		end
	endtask : arb

	// ----------------------------------------
	// read-data watcher and timeout
	// ----------------------------------------
	always @(posedge MCLK) begin
		if (rd_q) begin
			check("cfg_ack", CFG_ACK, 1'b1);
			check("cfg_rdata", CFG_RDATA, exp_q.pop_front());
		end
		if (wr_q) begin
			check("cfg_ack_wr", CFG_ACK, 1'b1);
		end
		rd_q = CFG_RD && RST_N;
		wr_q = CFG_WR && RST_N;
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = '0;
		{PKT_START, PKT_LEN, PKT_SLOW_TO_FAST, REQ, CREDIT_OK} = '0;
		RST_N = 1'b0;
		seed_v = $urandom(24087);
		repeat (2) @(posedge MCLK);
		#1;
		RST_N = 1'b1;
		rd(`SMAL_ACK_OFS, 32'h8000_0000);
		rd(`SMAL_MODE_OFS, 32'h0000_0002);
		rd(8'h7c, 32'h0);
		check("ack_latency", ACK_LATENCY, ADEF);
		$display("test reset done");
		d = $urandom() & 32'hbfff_efff;
		cfg(1'b1, `SMAL_ACK_OFS, 4'hf, d);
		rd(`SMAL_ACK_OFS, (d & `SMAL_ACK_CFG_MASK) | 32'h8000_0000);
		settle();
		check("ack_latency", ACK_LATENCY, ADEF);
		check("replay", REPLAY_TIMEOUT, RDEF);
		cfg(1'b1, `SMAL_ACK_OFS, 4'hf, 32'hffff_ffff);
		settle();
		check("ack_latency", ACK_LATENCY, 14'h3fff);
		check("replay", REPLAY_TIMEOUT, 12'hfff);
		cfg(1'b1, `SMAL_ACK_OFS, 4'h1, 32'h0);
		rd(`SMAL_ACK_OFS, 32'hffff_1f00);
		cfg(1'b1, 8'h7c, 4'hf, 32'hffff_ffff);
		rd(`SMAL_MODE_OFS, 32'h2);
		$display("test user values done");
		smal_load_model_i.send(`SMAL_ACK_OFS, 32'h0);
		settle();
		check("vga", VGA_DECODE_EN, 1'b0);
		check("ack_latency", ACK_LATENCY, ADEF);
		smal_load_model_i.send(`SMAL_MODE_OFS, 32'hffff_ffff);
		rd(`SMAL_MODE_OFS, 32'h7f);
		cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'hffff_ff80);
		rd(`SMAL_MODE_OFS, 32'h0);
		$display("test load done");
		for (int t = 0; t < 4; t++) begin
			cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'(t << 1));
			d = 32'd8 + ($urandom() % 32'd4000);
			pkt(d[11:0], 1'b1);
			check("fwd_start", FWD_START, (d >> 1) - 32'(t));
		end
		// short packet: start point clamps to the first cycle instead of wrapping
		cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'h6);
		pkt(12'd4, 1'b1);
		check("fwd_start", FWD_START, 32'd0);
		cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'h1);
		pkt(12'd100, 1'b0);
		check("fwd_start", FWD_START, 32'd100);
		cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'h70);
		settle();
		check("credit_all", CREDIT_ALL_TYPES, 1'b0);
		pkt(12'd100, 1'b0);
		check("fwd_start", FWD_START, 32'd0);
		@(posedge MCLK);
		#1;
		check("mode_out", {ORDER_TAG, ORDER_EGRESS, CREDIT_ALL_TYPES}, 3'b111);
		$display("test packet done");
		arb(4'b0010, 4'b0010, 1'b1, 2'd1);
		arb(4'b0010, 4'b0000, 1'b0, 2'd0);
		arb(4'b0110, 4'b0100, 1'b1, 2'd2);
		cfg(1'b1, `SMAL_MODE_OFS, 4'hf, 32'h8);
		pkt(12'd100, 1'b0);
		arb(4'b0110, 4'b0000, 1'b1, 2'd2);
		$display("test arbiter done");
		results();
	end
endmodule : smal_regs_tb_top

`default_nettype wire
